// ### logic/serial_cfg_pkg.sv
// Package: register map, field positions and types of the serial port block
`default_nettype none
package serial_cfg_pkg;
   localparam logic [3:0] CTRL_ONE_OFFSET = 4'h0;
   localparam logic [3:0] CTRL_TWO_OFFSET = 4'h4;
   localparam logic [3:0] STATUS_OFFSET = 4'h8;
   localparam logic [3:0] MASK_OFFSET = 4'hc;
   localparam int ROLE_BIT = 4;
   localparam int POLARITY_BIT = 3;
   localparam int PHASE_BIT = 2;
   localparam int SELECT_OE_BIT = 1;
   localparam int ORDER_BIT = 0;
   localparam int ENABLE_BIT = 6;
   localparam int FAULT_EN_BIT = 4;
   localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
   localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
   localparam logic [7:0] CTRL_TWO_MASK = 8'h1b;
   localparam logic [7:0] CTRL_ONE_MASK = 8'h7f;
   localparam int EVENT_DONE_BIT = 0;
   localparam int EVENT_FAULT_BIT = 1;
   localparam logic [1:0] EVENT_RESET = 2'h0;
   localparam int CLOCK_PERIOD_NS = 25;
   localparam int HALF_BIT_NS = 500;
   localparam int HALF_BIT_CYCLES = (HALF_BIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int BITS_PER_BYTE = 8;
   typedef struct packed
   {
      logic out;
      logic oe;
   } pin_drive_type;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_LEAD = 3'b010,
      ST_RUN = 3'b100
   } xfer_state_type;
endpackage : serial_cfg_pkg
`default_nettype wire

// ### logic/serial_cfg.sv
// Module: serial port with role, clock format, bit order and select-pin logic
`timescale 1ns/1ps
`default_nettype none
// Function
// - role bit: zero slave, one master
// - polarity bit inverts serial clock idle level
// - phase zero: first edge mid bit
// - phase one: first edge at bit start
// - order bit: zero msb first, one lsb
// - select pin function from three control bits
// - master without fault detect frees select pin
// - master fault detect, no output: fault input
// - second control reads zero in bits 7,6,5,2
module serial_cfg
(
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [3:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [3:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE_O,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE_O,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE_O,
   input wire logic SS_I,
   output logic SS_O,
   output logic SS_OE_O,
   output logic SS_GPIO_O,
   input wire logic [7:0] TX_DATA_I,
   input wire logic TX_VALID_I,
   output logic TX_READY_O,
   output logic [7:0] RX_DATA_O,
   output logic RX_VALID_O,
   output logic IRQ_O
);
   logic [7:0] ctrl_one_reg;
   logic [7:0] ctrl_two_reg;
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] mask_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [3:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic wstrb_reg;
   logic bvalid_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [2:0] sck_sync_reg;
   logic [2:0] ss_sync_reg;
   logic [2:0] mosi_sync_reg;
   logic [2:0] miso_sync_reg;
   logic sck_level_reg;
   logic ss_level_reg;
   serial_cfg_pkg::xfer_state_type state_reg;
   serial_cfg_pkg::xfer_state_type state_next;
   logic [7:0] shift_reg;
   logic [4:0] edge_cnt_reg;
   logic [5:0] half_cnt_reg;
   logic sck_int_reg;
   logic [7:0] rx_data_reg;
   logic rx_valid_reg;
   logic mosi_reg;
   serial_cfg_pkg::pin_drive_type ss_drive;
   wire is_master = ctrl_one_reg[serial_cfg_pkg::ROLE_BIT];
   wire polarity = ctrl_one_reg[serial_cfg_pkg::POLARITY_BIT];
   wire phase = ctrl_one_reg[serial_cfg_pkg::PHASE_BIT];
   wire lsb_first = ctrl_one_reg[serial_cfg_pkg::ORDER_BIT];
   wire sel_oe = ctrl_one_reg[serial_cfg_pkg::SELECT_OE_BIT];
   wire enabled = ctrl_one_reg[serial_cfg_pkg::ENABLE_BIT];
   wire fault_en = ctrl_two_reg[serial_cfg_pkg::FAULT_EN_BIT];
   wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire rd_fire = ARVALID_I && ARREADY_O;
   wire sck_changed = (sck_sync_reg[2] == sck_sync_reg[1]) && (sck_sync_reg[1] != sck_level_reg);
   wire ss_changed = (ss_sync_reg[2] == ss_sync_reg[1]) && (ss_sync_reg[1] != ss_level_reg);
   wire ss_in_low = !ss_level_reg;
   wire ss_is_gpio = is_master && !fault_en;
   wire ss_is_fault = is_master && fault_en && !sel_oe;
   wire ss_is_auto = is_master && fault_en && sel_oe;
   wire slave_sel = !is_master && enabled && ss_in_low;
   wire mode_fault = ss_is_fault && enabled && ss_in_low;
   wire half_done = half_cnt_reg == 6'(serial_cfg_pkg::HALF_BIT_CYCLES - 1);
   wire busy = state_reg != serial_cfg_pkg::ST_IDLE;
   wire start_master = is_master && enabled && TX_VALID_I && !busy && !mode_fault;
   // logical edge: leading edge moves away from idle
   wire slave_lead = sck_changed && (sck_sync_reg[1] != polarity);
   wire slave_trail = sck_changed && (sck_sync_reg[1] == polarity);
   // sample on leading edge when phase zero
   wire slave_sample = phase ? slave_trail : slave_lead;
   wire slave_shift = phase ? slave_lead : slave_trail;
   wire tx_msb = lsb_first ? TX_DATA_I[0] : TX_DATA_I[7];
   wire in_bit = is_master ? miso_sync_reg[2] : mosi_sync_reg[2];
   wire out_bit = lsb_first ? shift_reg[0] : shift_reg[7];
   wire [7:0] shift_in = lsb_first ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};
   wire [7:0] wr_masked = w_data_reg[7:0];
   wire [7:0] rd_mux = (ARADDR_I == serial_cfg_pkg::CTRL_ONE_OFFSET) ? ctrl_one_reg :
                       (ARADDR_I == serial_cfg_pkg::CTRL_TWO_OFFSET) ? ctrl_two_reg :
                       (ARADDR_I == serial_cfg_pkg::STATUS_OFFSET) ? {6'h00, status_reg} :
                       (ARADDR_I == serial_cfg_pkg::MASK_OFFSET) ? {6'h00, mask_reg} : 8'h00;
   wire rd_ok = (ARADDR_I[1:0] == 2'h0);
   wire wr_ok = (aw_addr_reg[1:0] == 2'h0);
   wire done_event = rx_valid_reg;
   wire clr_hit = wr_fire && wstrb_reg && (aw_addr_reg == serial_cfg_pkg::STATUS_OFFSET);
   assign AWREADY_O = !aw_hold_reg;
   assign WREADY_O = !w_hold_reg;
   assign BVALID_O = bvalid_reg;
   assign BRESP_O = wr_ok ? 2'h0 : 2'h2;
   assign ARREADY_O = !rvalid_reg;
   assign RVALID_O = rvalid_reg;
   assign RDATA_O = rdata_reg;
   assign RRESP_O = 2'h0;
   assign IRQ_O = |(status_reg & mask_reg);
   assign TX_READY_O = start_master || (!is_master && slave_sel && !busy);
   assign RX_DATA_O = rx_data_reg;
   assign RX_VALID_O = rx_valid_reg;
   assign SCK_O = sck_int_reg ^ polarity;
   assign SCK_OE_O = is_master && enabled;
   assign MOSI_O = mosi_reg;
   assign MOSI_OE_O = is_master && enabled;
   assign MISO_O = mosi_reg;
   assign MISO_OE_O = slave_sel;
   assign ss_drive.out = !(busy && is_master);
   assign ss_drive.oe = ss_is_auto && enabled;
   assign SS_O = ss_drive.out;
   assign SS_OE_O = ss_drive.oe;
   assign SS_GPIO_O = ss_is_gpio || !enabled;
   // role steers clock and data direction
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         serial_cfg_pkg::ST_IDLE:
            if (start_master || (slave_sel && !is_master))
               state_next = serial_cfg_pkg::ST_LEAD;
         serial_cfg_pkg::ST_LEAD:
            if (!is_master || half_done)
               state_next = serial_cfg_pkg::ST_RUN;
         serial_cfg_pkg::ST_RUN:
            if (edge_cnt_reg == 5'(2 * serial_cfg_pkg::BITS_PER_BYTE) || !enabled || mode_fault
                || (!is_master && !slave_sel))
               state_next = serial_cfg_pkg::ST_IDLE;
         default:
            state_next = serial_cfg_pkg::ST_IDLE;
      endcase
   end
   // Sticky events, set wins over clear
   assign status_next = (status_reg & ~(clr_hit ? wr_masked[1:0] : 2'h0))
                        | {mode_fault, done_event};
   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         ctrl_one_reg <= serial_cfg_pkg::CTRL_ONE_RESET;
         ctrl_two_reg <= serial_cfg_pkg::CTRL_TWO_RESET;
         mask_reg <= serial_cfg_pkg::EVENT_RESET;
         status_reg <= serial_cfg_pkg::EVENT_RESET;
      end
      else
      begin
         status_reg <= status_next;
         if (wr_fire && wstrb_reg && aw_addr_reg == serial_cfg_pkg::CTRL_ONE_OFFSET)
            ctrl_one_reg <= wr_masked & serial_cfg_pkg::CTRL_ONE_MASK;
         if (wr_fire && wstrb_reg && aw_addr_reg == serial_cfg_pkg::CTRL_TWO_OFFSET)
            ctrl_two_reg <= wr_masked & serial_cfg_pkg::CTRL_TWO_MASK;
         if (wr_fire && wstrb_reg && aw_addr_reg == serial_cfg_pkg::MASK_OFFSET)
            mask_reg <= wr_masked[1:0];
      end
   end
   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg <= 32'h0;
         wstrb_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end
      else
      begin
         if (AWVALID_I && AWREADY_O)
            aw_hold_reg <= 1'b1;
         if (AWVALID_I && AWREADY_O)
            aw_addr_reg <= AWADDR_I;
         if (WVALID_I && WREADY_O)
            w_hold_reg <= 1'b1;
         if (WVALID_I && WREADY_O)
            w_data_reg <= WDATA_I;
         if (WVALID_I && WREADY_O)
            wstrb_reg <= WSTRB_I[0];
         if (wr_fire)
            bvalid_reg <= 1'b1;
         else if (BREADY_I)
            bvalid_reg <= 1'b0;
         if (bvalid_reg && BREADY_I)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
         end
         if (rd_fire)
            rvalid_reg <= 1'b1;
         else if (RREADY_I)
            rvalid_reg <= 1'b0;
         if (rd_fire)
            rdata_reg <= rd_ok ? {24'h0, rd_mux} : 32'h0;
      end
   end
   // Three-stage pin synchronisers
   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         sck_sync_reg <= 3'h0;
         ss_sync_reg <= 3'h7;
         mosi_sync_reg <= 3'h0;
         miso_sync_reg <= 3'h0;
         sck_level_reg <= 1'b0;
         ss_level_reg <= 1'b1;
      end
      else
      begin
         sck_sync_reg <= {sck_sync_reg[1:0], SCK_I};
         ss_sync_reg <= {ss_sync_reg[1:0], SS_I};
         mosi_sync_reg <= {mosi_sync_reg[1:0], MOSI_I};
         miso_sync_reg <= {miso_sync_reg[1:0], MISO_I};
         if (sck_changed)
            sck_level_reg <= sck_sync_reg[1];
         if (ss_changed)
            ss_level_reg <= ss_sync_reg[1];
      end
   end
   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         state_reg <= serial_cfg_pkg::ST_IDLE;
         shift_reg <= 8'h00;
         edge_cnt_reg <= 5'h00;
         half_cnt_reg <= 6'h00;
         sck_int_reg <= 1'b0;
         rx_data_reg <= 8'h00;
         rx_valid_reg <= 1'b0;
         mosi_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         rx_valid_reg <= 1'b0;
         half_cnt_reg <= (busy && !half_done) ? half_cnt_reg + 6'h01 : 6'h00;
         if (state_reg == serial_cfg_pkg::ST_IDLE)
         begin
            edge_cnt_reg <= 5'h00;
            sck_int_reg <= 1'b0;
            if (TX_READY_O)
               shift_reg <= TX_DATA_I;
            if (TX_READY_O)
               mosi_reg <= tx_msb;
         end
         // phase one toggles clock at bit start
         else if (is_master && state_reg == serial_cfg_pkg::ST_LEAD && half_done && phase)
         begin
            sck_int_reg <= 1'b1;
            edge_cnt_reg <= 5'h01;
         end
         else if (is_master && state_reg == serial_cfg_pkg::ST_RUN && half_done)
         begin
            // phase zero first edge mid bit
            if (edge_cnt_reg != 5'(2 * serial_cfg_pkg::BITS_PER_BYTE))
               sck_int_reg <= !sck_int_reg;
            if (edge_cnt_reg != 5'(2 * serial_cfg_pkg::BITS_PER_BYTE))
               edge_cnt_reg <= edge_cnt_reg + 5'h01;
            if (edge_cnt_reg[0] == phase)
               shift_reg <= shift_in;
            if (edge_cnt_reg[0] != phase && edge_cnt_reg != 5'h00)
               mosi_reg <= out_bit;
            if (edge_cnt_reg == 5'(2 * serial_cfg_pkg::BITS_PER_BYTE - 1))
               rx_valid_reg <= 1'b1;
            // Last edge samples only in phase one
            if (edge_cnt_reg == 5'(2 * serial_cfg_pkg::BITS_PER_BYTE - 1))
               rx_data_reg <= phase ? shift_in : shift_reg;
         end
         else if (!is_master && state_reg == serial_cfg_pkg::ST_RUN && (slave_sample || slave_shift))
         begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
            if (slave_sample)
               shift_reg <= shift_in;
            if (slave_shift && edge_cnt_reg != 5'h00)
               mosi_reg <= out_bit;
            if (edge_cnt_reg == 5'(2 * serial_cfg_pkg::BITS_PER_BYTE - 1))
               rx_valid_reg <= 1'b1;
            if (edge_cnt_reg == 5'(2 * serial_cfg_pkg::BITS_PER_BYTE - 1))
               rx_data_reg <= slave_sample ? shift_in : shift_reg;
         end
      end
   end
   role_clock_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !is_master |-> !SCK_OE_O) else $error("clock driven in slave role");
   idle_polarity_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (SCK_OE_O && !busy) |-> (SCK_O == polarity)) else $error("idle clock level wrong");
   // no clock edge at bit start for phase zero
   phase_zero_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (is_master && !phase && state_reg == serial_cfg_pkg::ST_LEAD) |=> $stable(SCK_O))
      else $error("early edge with phase zero");
   // edge after lead for phase one
   phase_one_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (is_master && phase && state_reg == serial_cfg_pkg::ST_LEAD && half_done && $stable(ctrl_one_reg))
      |=> (SCK_O != polarity)) else $error("no first edge with phase one");
   // general use in master role when fault detect off
   select_gpio_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (is_master && !fault_en) |-> (SS_GPIO_O && !SS_OE_O)) else $error("select pin not freed");
   fault_input_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      mode_fault |=> status_reg[serial_cfg_pkg::EVENT_FAULT_BIT]) else $error("mode fault missed");
   slave_select_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !is_master |-> !SS_OE_O) else $error("select driven in slave role");
   ctrl_two_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (ctrl_two_reg & ~serial_cfg_pkg::CTRL_TWO_MASK) == 8'h00) else $error("reserved bits set");
   select_low_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (SS_OE_O && busy) |-> !SS_O) else $error("select high during byte");
endmodule : serial_cfg
`default_nettype wire

// ### dv/spi_far_side.sv
// Behavioural far-side serial device, playing slave or master for one byte
`timescale 1ns/1ps
`default_nettype none
module spi_far_side
(
   input wire logic lead_i,
   input wire logic pol_i,
   input wire logic pha_i,
   input wire logic ord_i,
   input wire logic sck_i,
   input wire logic ss_i,
   input wire logic din_i,
   output logic sck_o,
   output logic ss_o,
   output logic dout_o
);
   logic [7:0] tx_reg = 8'h00;
   logic [7:0] rx_reg = 8'h00;
   int bits = 0;
   int edges = 0;
   int races = 0;
   time din_at = 0;
   time smp_at = 1;
   initial
   begin
      sck_o = 1'b0;
      ss_o = 1'b1;
      dout_o = 1'b0;
   end
   function automatic int idx(input int k);
      return ord_i ? k : 7 - k;
   endfunction : idx
   always @(negedge ss_i)
   begin
      bits = 0;
      edges = 0;
      if (!pha_i)
         dout_o <= #5 tx_reg[idx(0)];
   end
   // Released line shows inverse of last bit
   always @(posedge ss_i)
      dout_o <= #5 ~dout_o;
   // sample and shift on proper edges
   always @(sck_i)
   begin
      if (ss_i === 1'b0)
      begin
         edges++;
         if ((sck_i != pol_i) != pha_i)
         begin
            if (din_at == $time)
               races++;
            smp_at = $time;
            rx_reg[idx(bits)] = din_i;
            bits++;
         end
         else if (bits < 8)
            dout_o <= #5 tx_reg[idx(bits)];
      end
   end
   // Data change on a sampling edge
   always @(din_i)
   begin
      din_at = $time;
      if (smp_at == $time && ss_i === 1'b0)
         races++;
   end
   // select low for whole frame, clock only inside it
   task automatic run_byte();
      begin
         sck_o = pol_i;
         #113;
         ss_o = 1'b0;
         // Select lead time covers the pin synchroniser
         #200;
         repeat (16)
         begin
            #100;
            sck_o = ~sck_o;
         end
         #100;
         ss_o = 1'b1;
      end
   endtask : run_byte
endmodule : spi_far_side
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] tx_data = 8'h00, rx_data, rx_seen = 8'h00;
   logic tx_valid = 1'b0, ss_low = 1'b0, f_lead = 1'b0, f_pol = 1'b0, f_pha = 1'b0, f_ord = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tx_ready, rx_valid, irq, f_sck, f_ss, f_dout;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, ss_gpio;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int bad_count = 0, check_count = 0, rx_count = 0;
   wire logic sck_w = sck_oe ? sck_o : f_sck;
   wire logic ss_w = ss_oe ? ss_o : (f_ss & ~ss_low);
   wire logic mosi_w = mosi_oe ? mosi_o : f_dout;
   wire logic miso_w = miso_oe ? miso_o : f_dout;
   wire logic f_din = f_lead ? miso_w : mosi_w;
   serial_cfg i_dut
   (
      .CLK_I(clk), .SYS_RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
      .WDATA_I(wdata), .WSTRB_I(4'h1), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .SCK_I(sck_w), .SCK_O(sck_o),
      .SCK_OE_O(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe), .MISO_I(miso_w),
      .MISO_O(miso_o), .MISO_OE_O(miso_oe), .SS_I(ss_w), .SS_O(ss_o), .SS_OE_O(ss_oe), .SS_GPIO_O(ss_gpio),
      .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .RX_DATA_O(rx_data),
      .RX_VALID_O(rx_valid), .IRQ_O(irq)
   );
   spi_far_side i_far
   (
      .lead_i(f_lead), .pol_i(f_pol), .pha_i(f_pha), .ord_i(f_ord), .sck_i(sck_w), .ss_i(ss_w),
      .din_i(f_din), .sck_o(f_sck), .ss_o(f_ss), .dout_o(f_dout)
   );
   always #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      if (rx_valid === 1'b1)
      begin
         rx_seen <= rx_data;
         rx_count <= rx_count + 1;
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      begin
         check_count++;
         if (seen !== exp)
         begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask : chk
   task automatic close_out();
      begin
         if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask : close_out
   task automatic axw(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= {24'h000000, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         r = 2'h3;
         for (int n = 0; n < 100; n++)
         begin
            @(posedge clk);
            if (awvalid && awready)
               awvalid <= 1'b0;
            if (wvalid && wready)
               wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
               r = bresp;
               bready <= 1'b0;
               break;
            end
         end
      end
   endtask : axw
   task automatic axr(input logic [3:0] a, output logic [31:0] d);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         d = 'x;
         for (int n = 0; n < 100; n++)
         begin
            @(posedge clk);
            if (arvalid && arready)
               arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
               d = rdata;
               rready <= 1'b0;
               break;
            end
         end
      end
   endtask : axr
   task automatic cfg(input logic [5:0] c, input logic lead);
      logic [1:0] r;
      logic [7:0] d;
      begin
         f_lead <= lead;
         f_pol <= c[2];
         f_pha <= c[1];
         f_ord <= c[0];
         axw(serial_cfg_pkg::CTRL_TWO_OFFSET, 8'(c[4]) << serial_cfg_pkg::FAULT_EN_BIT, r);
         d = 8'h00;
         d[serial_cfg_pkg::ENABLE_BIT] = 1'b1;
         d[serial_cfg_pkg::ROLE_BIT] = c[5];
         d[serial_cfg_pkg::POLARITY_BIT] = c[2];
         d[serial_cfg_pkg::PHASE_BIT] = c[1];
         d[serial_cfg_pkg::SELECT_OE_BIT] = c[3];
         d[serial_cfg_pkg::ORDER_BIT] = c[0];
         // phase change never paired with disable
         axw(serial_cfg_pkg::CTRL_ONE_OFFSET, d, r);
         repeat (3) @(posedge clk);
      end
   endtask : cfg
   task automatic send_wait(input logic [7:0] b, input int n, input logic far_lead);
      begin
         @(posedge clk);
         tx_data <= b;
         tx_valid <= 1'b1;
         if (far_lead)
            fork
               i_far.run_byte();
            join_none
         for (int c = 0; c < 500; c++)
         begin
            @(posedge clk);
            if (tx_ready === 1'b1)
               break;
         end
         tx_valid <= 1'b0;
         for (int c = 0; c < 2000 && rx_count == n; c++)
            @(posedge clk);
         repeat (serial_cfg_pkg::HALF_BIT_CYCLES + 4) @(posedge clk);
      end
   endtask : send_wait
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      begin
         axr(serial_cfg_pkg::CTRL_ONE_OFFSET, d);
         chk("control one reset", d, {24'h0, serial_cfg_pkg::CTRL_ONE_RESET});
         axr(serial_cfg_pkg::CTRL_TWO_OFFSET, d);
         chk("control two reset", d, {24'h0, serial_cfg_pkg::CTRL_TWO_RESET});
         axw(serial_cfg_pkg::CTRL_TWO_OFFSET, 8'hff, r);
         axr(serial_cfg_pkg::CTRL_TWO_OFFSET, d);
         chk("control two bits", d, 32'h0000001b);
         axw(serial_cfg_pkg::CTRL_TWO_OFFSET, 8'h00, r);
         axw(4'h2, 8'hff, r);
         chk("unaligned resp", r, 2'h2);
         axr(4'h2, d);
         chk("unaligned read", d, 32'h0);
         chk("read resp", rresp, 2'h0);
      end
   endtask : t_regs
   task automatic t_select();
      logic [2:0] k;
      begin
         for (int i = 0; i < 8; i++)
         begin
            k = 3'(i);
            cfg({k, 3'h0}, 1'b0);
            chk("select free", ss_gpio, k[2] & ~k[1]);
            chk("select drive", ss_oe, k[2] & k[1] & k[0]);
            chk("clock drive", sck_oe, k[2]);
         end
      end
   endtask : t_select
   task automatic t_master(input logic [2:0] k, input logic [7:0] tb, input logic [7:0] sb);
      begin
         cfg({3'h7, k}, 1'b0);
         i_far.tx_reg = sb;
         i_far.races = 0;
         i_far.edges = 0;
         chk("clock idle", sck_w, k[2]);
         send_wait(tb, rx_count, 1'b0);
         chk("select idle", ss_w, 1'b1);
         chk("byte out", i_far.rx_reg, tb);
         chk("byte in", rx_seen, sb);
         chk("clock edges", i_far.edges, 16);
         chk("data races", i_far.races, 0);
      end
   endtask : t_master
   task automatic t_slave(input logic [2:0] k, input logic [7:0] tb, input logic [7:0] fb);
      begin
         cfg({1'b0, k[1:0], k}, 1'b1);
         i_far.tx_reg = fb;
         send_wait(tb, rx_count, 1'b1);
         chk("slave byte in", rx_seen, fb);
         chk("slave byte out", i_far.rx_reg, tb);
      end
   endtask : t_slave
   task automatic t_irq();
      logic [31:0] d;
      logic [1:0] r;
      begin
         axr(serial_cfg_pkg::STATUS_OFFSET, d);
         chk("done flag", d, 32'h1);
         chk("irq masked", irq, 1'b0);
         axw(serial_cfg_pkg::MASK_OFFSET, 8'h03, r);
         repeat (2) @(posedge clk);
         chk("irq raised", irq, 1'b1);
         axw(serial_cfg_pkg::STATUS_OFFSET, 8'h01, r);
         repeat (2) @(posedge clk);
         chk("irq cleared", irq, 1'b0);
         cfg(6'h30, 1'b0);
         ss_low <= 1'b1;
         repeat (6) @(posedge clk);
         ss_low <= 1'b0;
         axr(serial_cfg_pkg::STATUS_OFFSET, d);
         chk("fault flag", d, 32'h2);
         chk("irq fault", irq, 1'b1);
         axw(serial_cfg_pkg::STATUS_OFFSET, 8'h02, r);
         repeat (2) @(posedge clk);
         chk("irq idle", irq, 1'b0);
      end
   endtask : t_irq
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_select();
      for (int i = 0; i < 8; i++)
         t_master(3'(i), 8'h4b ^ 8'(i * 37), 8'hd2 ^ 8'(i * 11));
      t_slave(3'h0, 8'h3a, 8'hc5);
      t_slave(3'h7, 8'h61, 8'h9e);
      t_irq();
      close_out();
   end
endmodule : testbench
`default_nettype wire
